// >>> logic/bpd_consts.svh
`ifndef BPD_CONSTS_SVH
`define BPD_CONSTS_SVH

// register byte offsets
`define BPD_OFS_CTRL 4'h0
`define BPD_OFS_STATUS 4'h4
`define BPD_OFS_SPACING 4'h8

// register reset values and writable bits
`define BPD_CTRL_RESET 32'h0000_0000
`define BPD_CTRL_WMASK 32'h001F_FFFF

// buffer geometry
`define BPD_BUF_BYTES 6'h20
`define BPD_BUF_WORDS 4'h8
`define BPD_FIFO_DEPTH 4
`define BPD_DATA_W 32

// extra cycles, one nibble per ratio, 2:1 in bits 3:0 up to 5:1 in bits 15:12
`define BPD_T3_M2P 16'h2223
`define BPD_T3_P2M_H0 16'h2234
`define BPD_T3_P2M_HN 16'h1223
`define BPD_T4_PF1_CL2_H0 16'h567B
`define BPD_T4_PF1_CL2_HN 16'h457A
`define BPD_T4_PF1_CL3_H0 16'h568B
`define BPD_T4_PF1_CL3_HN 16'h457A
`define BPD_T4_PF2_CL2_H0 16'h568C
`define BPD_T4_PF2_CL2_HN 16'h567B
`define BPD_T4_PF2_CL3_H0 16'h568C
`define BPD_T4_PF2_CL3_HN 16'h568B
`define BPD_T4_PF4_CL2_H0 16'h679E
`define BPD_T4_PF4_CL2_HN 16'h579D
`define BPD_T4_PF4_CL3_H0 16'h67AE
`define BPD_T4_PF4_CL3_HN 16'h679D
`define BPD_T4_P2M_H0 16'h4569
`define BPD_T4_P2M_HN 16'h3458

`endif

// >>> logic/bpd_pkg.sv
package bpd_pkg;

  typedef enum logic [2:0] {
    bpd_st_idle = 3'b000,
    bpd_st_load = 3'b001,
    bpd_st_setup = 3'b010,
    bpd_st_ack = 3'b011,
    bpd_st_hold = 3'b100,
    bpd_st_gap = 3'b101,
    bpd_st_flush = 3'b110
  } bpd_state_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic cas_latency_setting;
    logic [1:0] clk_ratio;
    logic [1:0] prefetch_count;
    logic [2:0] hold_cycles;
    logic [5:0] wait_cycles;
    logic [1:0] setup_cycles;
    logic buffer_enable;
    logic [1:0] periph_width;
    logic xfer_direction;
    logic enable;
  } bpd_ctrl_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bpd_av_req_t;

endpackage : bpd_pkg

// >>> logic/bpd_fifo.sv
`timescale 1ns/100ps
module bpd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int CW = $clog2(DEPTH + 1);

  // shift register, so the head is always a flop
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [CW-1:0] count_q;
  logic full_q;
  logic valid_q;

  wire push = in_valid && !full_q;
  wire pop = valid_q && out_ready;
  wire [CW-1:0] count_d = count_q + CW'(push) - CW'(pop);
  wire [CW-1:0] wpos = pop ? count_q - CW'(1) : count_q;

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    if (i < DEPTH - 1) begin : g_mid
      assign mem_d[i] = (push && wpos == CW'(i)) ? in_data : pop ? mem_q[i + 1] : mem_q[i];
    end else begin : g_top
      assign mem_d[i] = (push && wpos == CW'(i)) ? in_data : mem_q[i];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q <= '0;
      full_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      count_q <= count_d;
      full_q <= count_d == CW'(DEPTH);
      valid_q <= count_d != '0;
    end
  end

  always_ff @(posedge clk) begin
    mem_q <= mem_d;
  end

  assign in_ready = !full_q;
  assign out_valid = valid_q;
  assign out_data = mem_q[0];

endmodule : bpd_fifo

// >>> logic/bpd_dma_channel.sv
// How it works
// - buffered-only acks add ratio-dependent extra cycles
// - one SDRAM access when buffer fills/empties
// - memory-access spacing: setup+1+wait+hold+memory extra
// - prefetch one doubleword: memory extra table
// - prefetch two doublewords: memory extra table
// - prefetch four doublewords: memory extra table
// - peripheral-to-memory last item memory extra, any latency
// - peripheral-to-memory fills 32 bytes per item width
// - inbound buffer cycle: (items-1) buffered plus memory
// - outbound buffer holds only prefetched doublewords
// - outbound buffer cycle: (items-1) buffered plus memory
// - memory spacing includes last item transfer
// - ack active one cycle plus wait cycles
// - prefetch codes select one, two, four doublewords
// - setup 0-3 idle, ack 1+wait, hold 0-7
// - buffered spacing: setup+1+wait+hold+buffered extra
// - flush buffer when request drops
`timescale 1ns/100ps
`include "bpd_consts.svh"
module bpd_dma_channel #(
  parameter int FIFO_DEPTH = `BPD_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire bpd_pkg::bpd_av_req_t av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  // peripheral pins
  input wire logic dma_request_line,
  output logic dma_ack_strobe,
  input wire logic [31:0] periph_data_in,
  output logic [31:0] periph_data_out,
  output logic periph_data_oe_n,
  // sdram write stream
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [31:0] mem_wr_data,
  // sdram read stream
  input wire logic mem_rd_valid,
  output logic mem_rd_ready,
  input wire logic [31:0] mem_rd_data
);
  import bpd_pkg::*;

  localparam int NBYTES = 32;

  bpd_ctrl_t ctrl_q;
  bpd_ctrl_t ctrl_d;
  logic av_wait_q;
  logic [31:0] rdata_q;
  bpd_state_t state_q;
  bpd_state_t state_d;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [5:0] ptr_q;
  logic [5:0] ptr_d;
  logic [3:0] mw_q;
  logic [3:0] mw_d;
  logic last_q;
  logic last_d;
  logic [1:0] req_sync_q;
  logic [31:0] pd_meta_q;
  logic [31:0] pd_sync_q;
  logic [7:0] bytes_q [NBYTES];
  logic [7:0] bytes_d [NBYTES];
  logic [31:0] item_word;
  logic ack_q;
  logic oe_n_q;
  logic [31:0] pd_out_q;
  logic rd_ready_q;
  logic [15:0] gap_cnt_q;
  logic [15:0] spacing_q;
  logic [15:0] item_cnt_q;
  logic seen_ack_q;
  logic fifo_in_ready;

  // register access, answer one cycle after the request appears
  wire av_any = av_req.read || av_req.write;
  wire av_take = av_any && !av_wait_q;
  wire sel_ctrl = av_req.address == `BPD_OFS_CTRL;
  wire sel_status = av_req.address == `BPD_OFS_STATUS;
  wire sel_spacing = av_req.address == `BPD_OFS_SPACING;
  wire [31:0] be_mask = {{8{av_req.byteenable[3]}}, {8{av_req.byteenable[2]}},
                         {8{av_req.byteenable[1]}}, {8{av_req.byteenable[0]}}};
  wire [31:0] wr_mask = be_mask & `BPD_CTRL_WMASK;
  wire ctrl_wr = av_take && av_req.write && sel_ctrl;
  assign ctrl_d = ctrl_wr ? bpd_ctrl_t'((ctrl_q & ~wr_mask) | (av_req.writedata & wr_mask)) : ctrl_q;
  wire req_s = req_sync_q[1];
  wire [31:0] status_w = {item_cnt_q, 5'h00, req_s, ptr_q, last_q, state_q};
  wire [31:0] spacing_w = {16'h0000, spacing_q};
  wire [31:0] rd_mux = sel_ctrl ? 32'(ctrl_q) : sel_status ? status_w : sel_spacing ? spacing_w : 32'h0000_0000;

  // configuration decode
  wire m2p = !ctrl_q.xfer_direction;
  wire hold_nz = ctrl_q.hold_cycles != 3'h0;
  wire [1:0] pw_eff = (ctrl_q.periph_width == 2'h3) ? 2'h2 : ctrl_q.periph_width;
  wire [5:0] item_bytes = 6'h01 << pw_eff;
  wire [1:0] pf_eff = (ctrl_q.prefetch_count == 2'h3) ? 2'h0 : ctrl_q.prefetch_count;
  wire [2:0] dw_count = 3'h1 << pf_eff;
  wire [5:0] cap_bytes = m2p ? {dw_count, 3'h0} : `BPD_BUF_BYTES;
  wire [3:0] load_words = {dw_count, 1'b0};

  function automatic logic [15:0] m2p_row(input logic [1:0] pf, input logic cl3, input logic hnz);
    case ({pf, cl3, hnz})
      4'h0: m2p_row = `BPD_T4_PF1_CL2_H0;
      4'h1: m2p_row = `BPD_T4_PF1_CL2_HN;
      4'h2: m2p_row = `BPD_T4_PF1_CL3_H0;
      4'h3: m2p_row = `BPD_T4_PF1_CL3_HN;
      4'h4: m2p_row = `BPD_T4_PF2_CL2_H0;
      4'h5: m2p_row = `BPD_T4_PF2_CL2_HN;
      4'h6: m2p_row = `BPD_T4_PF2_CL3_H0;
      4'h7: m2p_row = `BPD_T4_PF2_CL3_HN;
      4'h8: m2p_row = `BPD_T4_PF4_CL2_H0;
      4'h9: m2p_row = `BPD_T4_PF4_CL2_HN;
      4'hA: m2p_row = `BPD_T4_PF4_CL3_H0;
      4'hB: m2p_row = `BPD_T4_PF4_CL3_HN;
      default: m2p_row = `BPD_T4_PF1_CL2_H0;
    endcase
  endfunction : m2p_row

  // extra cycle selection
  wire [15:0] row_buf = m2p ? `BPD_T3_M2P : hold_nz ? `BPD_T3_P2M_HN : `BPD_T3_P2M_H0;
  wire [15:0] row_m2p = m2p_row(pf_eff, ctrl_q.cas_latency_setting, hold_nz);
  wire [15:0] row_mem = m2p ? row_m2p : hold_nz ? `BPD_T4_P2M_HN : `BPD_T4_P2M_H0;
  wire [3:0] ratio_sh = {ctrl_q.clk_ratio, 2'h0};
  wire [3:0] extra_buf = row_buf[ratio_sh +: 4];
  wire [3:0] extra_mem = row_mem[ratio_sh +: 4];

  // item sequencing terms
  wire cnt_zero = cnt_q == 7'h00;
  wire [5:0] ptr_adv = ptr_q + item_bytes;
  wire adv_last = ptr_adv >= cap_bytes;
  wire [3:0] extra_now = adv_last ? extra_mem : extra_buf;
  wire [3:0] extra_held = last_q ? extra_mem : extra_buf;
  wire setup_zero = ctrl_q.setup_cycles == 2'h0;
  wire [6:0] wait_cnt = 7'(ctrl_q.wait_cycles);
  wire [6:0] hold_cnt = 7'(ctrl_q.hold_cycles) - 7'h01;
  wire [6:0] setup_cnt = 7'(ctrl_q.setup_cycles) - 7'h01;
  wire bpd_state_t first_state = setup_zero ? bpd_st_ack : bpd_st_setup;
  wire [6:0] first_cnt = setup_zero ? wait_cnt : setup_cnt;
  wire run_ok = ctrl_q.enable && ctrl_q.buffer_enable && req_s;

  // memory side
  wire in_gap_mem = state_q == bpd_st_gap && last_q;
  wire mem_active = state_q == bpd_st_load || in_gap_mem || state_q == bpd_st_flush;
  wire [5:0] flush_words = (ptr_q + 6'h03) >> 2;
  wire [3:0] mw_tgt = m2p ? load_words : (state_q == bpd_st_flush) ? flush_words[3:0] : `BPD_BUF_WORDS;
  wire mem_done = mw_q == mw_tgt;
  // complete words leave early, so the memory gap only carries the last one
  wire word_full = ({mw_q, 2'h0} + 6'h04) <= ptr_q;
  wire fifo_in_valid = (mem_active || word_full) && !m2p && !mem_done;
  // outbound: next item may start once its word has arrived
  wire [5:0] next_ptr = last_q ? 6'h00 : ptr_q;
  wire words_ok = {mw_q, 2'h0} > next_ptr;
  wire fifo_push = fifo_in_valid && fifo_in_ready;
  wire rd_accept = mem_rd_valid && rd_ready_q;
  wire [4:0] mw_byte = {mw_q[2:0], 2'h0};
  wire [31:0] fifo_din = {bytes_q[mw_byte + 5'h03], bytes_q[mw_byte + 5'h02],
                          bytes_q[mw_byte + 5'h01], bytes_q[mw_byte]};
  wire cap_en = state_q == bpd_st_ack && cnt_zero && !m2p;

  // per byte: capture from peripheral or load from sdram
  for (genvar b = 0; b < NBYTES; b++) begin : g_byte
    wire [5:0] bpos = 6'(b);
    wire [5:0] lane = bpos - ptr_q;
    wire [5:0] lw = bpos - {mw_q, 2'h0};
    wire cap_hit = cap_en && bpos >= ptr_q && lane < item_bytes;
    wire load_hit = rd_accept && bpos >= {mw_q, 2'h0} && lw < 6'h04;
    assign bytes_d[b] = cap_hit ? pd_sync_q[{lane[1:0], 3'h0} +: 8] :
                        load_hit ? mem_rd_data[{lw[1:0], 3'h0} +: 8] : bytes_q[b];
  end

  // outbound item, narrow widths in the low lanes
  for (genvar i = 0; i < 4; i++) begin : g_lane
    wire [4:0] idx = 5'(ptr_d + 6'(i));
    assign item_word[8 * i +: 8] = (6'(i) < item_bytes) ? bytes_q[idx] : 8'h00;
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    last_d = last_q;
    mw_d = mw_q + 4'(fifo_push || rd_accept);
    case (state_q)
      bpd_st_idle: begin
        ptr_d = 6'h00;
        mw_d = 4'h0;
        last_d = 1'b0;
        if (run_ok) begin
          if (m2p) begin
            state_d = bpd_st_load;
          end else begin
            state_d = first_state;
            cnt_d = first_cnt;
          end
        end
      end
      bpd_st_load: begin
        if (mem_done) begin
          state_d = first_state;
          cnt_d = first_cnt;
        end
      end
      bpd_st_setup: begin
        if (cnt_zero) begin
          state_d = bpd_st_ack;
          cnt_d = wait_cnt;
        end else begin
          cnt_d = cnt_q - 7'h01;
        end
      end
      bpd_st_ack: begin
        if (cnt_zero) begin
          ptr_d = ptr_adv;
          last_d = adv_last;
          if (m2p && adv_last) begin
            mw_d = 4'h0;
          end
          if (hold_nz) begin
            state_d = bpd_st_hold;
            cnt_d = hold_cnt;
          end else begin
            state_d = bpd_st_gap;
            cnt_d = 7'(extra_now) - 7'h01;
          end
        end else begin
          cnt_d = cnt_q - 7'h01;
        end
      end
      bpd_st_hold: begin
        if (cnt_zero) begin
          state_d = bpd_st_gap;
          cnt_d = 7'(extra_held) - 7'h01;
        end else begin
          cnt_d = cnt_q - 7'h01;
        end
      end
      bpd_st_gap: begin
        if (!cnt_zero) begin
          cnt_d = cnt_q - 7'h01;
        end else if (m2p ? words_ok : (!last_q || mem_done)) begin
          // a stalled sdram access stretches the gap rather than losing data
          if (last_q) begin
            ptr_d = 6'h00;
            if (!m2p) begin
              mw_d = 4'h0;
            end
          end
          last_d = 1'b0;
          if (run_ok) begin
            state_d = first_state;
            cnt_d = first_cnt;
          end else if (!m2p && ptr_d != 6'h00) begin
            state_d = bpd_st_flush;
          end else begin
            state_d = bpd_st_idle;
          end
        end
      end
      bpd_st_flush: begin
        if (mem_done) begin
          state_d = bpd_st_idle;
          ptr_d = 6'h00;
        end
      end
      default: begin
        state_d = bpd_st_idle;
      end
    endcase
  end

  wire rd_ready_d = m2p && state_d != bpd_st_idle && state_d != bpd_st_flush && mw_d < load_words;
  wire drive_next = m2p && (state_d == bpd_st_setup || state_d == bpd_st_ack);
  wire ack_rise = state_d == bpd_st_ack && state_q != bpd_st_ack;
  wire gap_full = gap_cnt_q == 16'hFFFF;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= bpd_ctrl_t'(`BPD_CTRL_RESET);
      av_wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      req_sync_q <= 2'h0;
      pd_meta_q <= 32'h0000_0000;
      pd_sync_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      av_wait_q <= !(av_any && av_wait_q);
      if (av_req.read && av_wait_q) begin
        rdata_q <= rd_mux;
      end
      req_sync_q <= {req_sync_q[0], dma_request_line};
      pd_meta_q <= periph_data_in;
      pd_sync_q <= pd_meta_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= bpd_st_idle;
      cnt_q <= 7'h00;
      ptr_q <= 6'h00;
      mw_q <= 4'h0;
      last_q <= 1'b0;
      ack_q <= 1'b0;
      oe_n_q <= 1'b1;
      pd_out_q <= 32'h0000_0000;
      rd_ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      mw_q <= mw_d;
      last_q <= last_d;
      ack_q <= state_d == bpd_st_ack;
      oe_n_q <= !drive_next;
      pd_out_q <= item_word;
      rd_ready_q <= rd_ready_d;
    end
  end

  always_ff @(posedge clk) begin
    bytes_q <= bytes_d;
  end

  // ack-to-ack spacing monitor for software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_cnt_q <= 16'h0000;
      spacing_q <= 16'h0000;
      item_cnt_q <= 16'h0000;
      seen_ack_q <= 1'b0;
    end else if (ack_rise) begin
      gap_cnt_q <= 16'h0000;
      seen_ack_q <= 1'b1;
      item_cnt_q <= item_cnt_q + 16'h0001;
      if (seen_ack_q) begin
        spacing_q <= gap_cnt_q + 16'h0001;
      end
    end else if (!gap_full) begin
      gap_cnt_q <= gap_cnt_q + 16'h0001;
    end
  end

  bpd_fifo #(
    .WIDTH(`BPD_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_din),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data(mem_wr_data)
  );

  assign av_readdata = rdata_q;
  assign av_waitrequest = av_wait_q;
  assign dma_ack_strobe = ack_q;
  assign periph_data_out = pd_out_q;
  assign periph_data_oe_n = oe_n_q;
  assign mem_rd_ready = rd_ready_q;

endmodule : bpd_dma_channel

// >>> tb/bpd_chk_sva.sv
`timescale 1ns/100ps
module bpd_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // watched ports
  input wire bpd_pkg::bpd_av_req_t av_req,
  input wire logic av_waitrequest,
  input wire logic dma_ack_strobe,
  input wire logic periph_data_oe_n,
  input wire logic mem_wr_valid,
  input wire logic mem_wr_ready,
  input wire logic [31:0] mem_wr_data
);
  import bpd_pkg::*;
  // shadow of the control word, rebuilt from bus writes
  bpd_ctrl_t ctrl_q;
  logic [31:0] be_m;
  logic [6:0] hi_q;
  logic [6:0] lo_q;
  logic [7:0] sp_q;
  assign be_m = {{8{av_req.byteenable[3]}}, {8{av_req.byteenable[2]}},
    {8{av_req.byteenable[1]}}, {8{av_req.byteenable[0]}}};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= '0;
      hi_q <= 7'h00;
      lo_q <= 7'h00;
      sp_q <= 8'hFF;
    end else begin
      if (av_req.write && !av_waitrequest && av_req.address == 4'h0) begin
        ctrl_q <= bpd_ctrl_t'((ctrl_q & ~be_m) | (av_req.writedata & be_m & 32'h001F_FFFF));
      end
      hi_q <= dma_ack_strobe ? hi_q + 7'h01 : 7'h00;
      lo_q <= periph_data_oe_n ? 7'h00 : lo_q + 7'h01;
      // saturates so a long stall cannot wrap into a short gap
      sp_q <= $rose(dma_ack_strobe) ? 8'h01 : (sp_q == 8'hFF ? sp_q : sp_q + 8'h01);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_ack_len;
    $fell(dma_ack_strobe) |-> hi_q == ctrl_q.wait_cycles + 7'h01;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("strobe width wrong");
  property p_oe_len;
    $rose(periph_data_oe_n) |-> lo_q == ctrl_q.setup_cycles + ctrl_q.wait_cycles + 7'h01;
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("drive window wrong");
  property p_spacing;
    $rose(dma_ack_strobe) |-> sp_q >= ctrl_q.setup_cycles + ctrl_q.wait_cycles + ctrl_q.hold_cycles + 8'h02;
  endproperty
  a_spacing: assert property (p_spacing) else $error("strobes too close");
  property p_ben_off;
    !ctrl_q.buffer_enable |-> !dma_ack_strobe;
  endproperty
  a_ben_off: assert property (p_ben_off) else $error("strobe without buffer");
  property p_p2m_oe;
    ctrl_q.xfer_direction |-> periph_data_oe_n;
  endproperty
  a_p2m_oe: assert property (p_p2m_oe) else $error("drives pins while inbound");
  property p_m2p_wr;
    !ctrl_q.xfer_direction |-> !mem_wr_valid;
  endproperty
  a_m2p_wr: assert property (p_m2p_wr) else $error("memory write while outbound");
  property p_wr_hold;
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write word dropped");
  property p_ans;
    (av_req.read || av_req.write) && av_waitrequest |=> !av_waitrequest ##1 av_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer timing wrong");
endmodule : bpd_chk

// >>> tb/bpd_periph_model.sv
`timescale 1ns/100ps
module bpd_periph_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bench control
  input wire logic req_on,
  // device pins
  output logic dma_request_line = 1'b0,
  input wire logic dma_ack_strobe,
  output logic [31:0] periph_data_in = 32'hA500_0000,
  // strobes seen
  output logic [15:0] acks = 16'h0000
);
  logic ack_q = 1'b0;
  always @(posedge clk) begin
    ack_q <= dma_ack_strobe;
    dma_request_line <= req_on;
    if (sys_rst) begin
      acks <= 16'h0000;
      periph_data_in <= 32'hA500_0000;
    end else if (ack_q && !dma_ack_strobe) begin
      // next item only once the strobe ends, so the synchroniser sees it settled
      acks <= acks + 16'h0001;
      periph_data_in <= periph_data_in + 32'h0000_0001;
    end
  end
endmodule : bpd_periph_model

// >>> tb/test_buffered_periph_dma_ack_timing.sv
`timescale 1ns/100ps
module test_buffered_periph_dma_ack_timing;
  import bpd_pkg::*;
  bpd_av_req_t av_req = '0;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_on = 1'b0;
  logic mem_wr_ready = 1'b1;
  logic mem_rd_valid = 1'b1;
  logic ack_p = 1'b0;
  logic [7:0] sp = 8'h00;
  logic [31:0] mem_rd_data = 32'h0;
  logic dma_request_line, dma_ack_strobe, periph_data_oe_n, mem_wr_valid, mem_rd_ready, av_waitrequest;
  logic [31:0] av_readdata, periph_data_in, periph_data_out, mem_wr_data, wd_last;
  logic [15:0] acks;
  int mismatches, compares, cyc, wn;
  // memory-access extra cycles, index prefetch*4 + latency*2 + hold
  logic [15:0] ct [12] = '{16'h567B, 16'h457A, 16'h568B, 16'h457A, 16'h568C, 16'h567B,
    16'h568C, 16'h568B, 16'h679E, 16'h579D, 16'h67AE, 16'h679D};
  bpd_dma_channel #(.FIFO_DEPTH(4)) dut (.clk(clk), .sys_rst(sys_rst), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .dma_request_line(dma_request_line),
    .dma_ack_strobe(dma_ack_strobe), .periph_data_in(periph_data_in), .periph_data_out(periph_data_out),
    .periph_data_oe_n(periph_data_oe_n), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_data(mem_wr_data), .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready),
    .mem_rd_data(mem_rd_data));
  bpd_periph_model u_per (.clk(clk), .sys_rst(sys_rst), .req_on(req_on),
    .dma_request_line(dma_request_line), .dma_ack_strobe(dma_ack_strobe),
    .periph_data_in(periph_data_in), .acks(acks));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ack_p <= dma_ack_strobe;
    sp <= (dma_ack_strobe && !ack_p) ? 8'h01 : sp + 8'h01;
    if (mem_rd_valid && mem_rd_ready) mem_rd_data <= mem_rd_data + 32'h1;
    if (mem_wr_valid && mem_wr_ready) begin
      wn <= wn + 1;
      wd_last <= mem_wr_data;
    end
    if (cyc == 80000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    av_req.read <= ~wr;
    av_req.write <= wr;
    av_req.address <= a;
    av_req.writedata <= d;
    av_req.byteenable <= 4'hF;
    do @(posedge clk); while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
  endtask : av
  // polls status until the channel has flushed, then switches it off
  task automatic idle;
    logic [31:0] r;
    do av(1'b0, 4'h4, 32'h0, r); while (r[2:0] !== 3'h0 || mem_wr_valid !== 1'b0);
    av(1'b1, 4'h0, 32'h0, r);
  endtask : idle
  function automatic int nib(input logic [15:0] v, input int rt);
    return int'(v >> (4 * rt)) & 15;
  endfunction : nib
  task automatic run(input int dir, w, s, wt, hd, pf, rt, cl, n, xb, xc);
    logic [31:0] r;
    int k, b;
    b = s + 1 + wt + hd;
    av(1'b1, 4'h0, {11'h0, cl[0], rt[1:0], pf[1:0], hd[2:0], wt[5:0], s[1:0], 1'b1, w[1:0], dir[0], 1'b1}, r);
    req_on <= 1'b1;
    for (k = 0; k <= 2 * n; k++) begin
      do @(posedge clk); while (!(dma_ack_strobe && !ack_p));
      if (k % n != 0) chk(sp, b + xb);
      else if (k > 0) chk(sp, b + xc);
    end
    req_on <= 1'b0;
    idle();
  endtask : run
  task automatic t_regs;
    logic [31:0] r;
    av(1'b0, 4'h0, 32'h0, r);
    chk(r, 32'h0);
    av(1'b1, 4'h0, 32'hFFFF_FFFF, r);
    av(1'b0, 4'h0, 32'h0, r);
    chk(r, 32'h001F_FFFF);
    av(1'b1, 4'hC, 32'hFFFF_FFFF, r);
    av(1'b0, 4'hC, 32'h0, r);
    chk(r, 32'h0);
    av(1'b1, 4'h0, 32'h0, r);
    $display("register test done");
  endtask : t_regs
  // sink held off: fifo fills and the channel must wait with the full buffer
  task automatic t_stall;
    logic [31:0] r;
    int a0, w0;
    a0 = acks;
    w0 = wn;
    mem_wr_ready <= 1'b0;
    av(1'b1, 4'h0, {11'h0, 1'b0, 2'h0, 2'h0, 3'h1, 6'h3F, 2'h0, 1'b1, 2'h2, 1'b1, 1'b1}, r);
    req_on <= 1'b1;
    repeat (1200) @(posedge clk);
    chk(acks - a0, 8);
    chk(mem_wr_valid, 1);
    av(1'b0, 4'h8, 32'h0, r);
    chk(r, 32'd68);
    av(1'b0, 4'h4, 32'h0, r);
    chk(r & 32'h0000_07FF, 32'h0000_060D);
    mem_wr_ready <= 1'b1;
    req_on <= 1'b0;
    idle();
    chk(wn - w0, acks - a0);
    chk(wd_last, 32'hA500_0000 + acks - 1);
    $display("stall test done");
  endtask : t_stall
  task automatic t_p2m(input int rt, h, w);
    int hd;
    hd = h ? 2 * rt + 1 : 0;
    run(1, w, 3 * h, rt, hd, 0, rt, rt % 2, 32 >> w, nib(h ? 16'h1223 : 16'h2234, rt),
      nib(h ? 16'h3458 : 16'h4569, rt));
    $display("inbound ratio %0d hold %0d width %0d done", rt + 2, hd, w);
  endtask : t_p2m
  task automatic t_m2p(input int rt, h, pf, cl);
    int hd;
    hd = h ? 7 - 2 * rt : 0;
    run(0, pf, rt, 2 * h, hd, pf, rt, cl, 8, nib(16'h2223, rt), nib(ct[pf * 4 + cl * 2 + h], rt));
    $display("outbound ratio %0d hold %0d prefetch %0d latency %0d done", rt + 2, hd, pf, cl + 2);
  endtask : t_m2p
  initial begin
    int rt, h, w, pf;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_stall();
    for (rt = 0; rt < 4; rt++) begin
      for (h = 0; h < 2; h++) begin
        for (w = 0; w < 3; w++) t_p2m(rt, h, w);
        for (pf = 0; pf < 6; pf++) t_m2p(rt, h, pf / 2, pf % 2);
      end
    end
    conclude();
  end
endmodule : test_buffered_periph_dma_ack_timing
bind bpd_dma_channel bpd_chk u_chk (.clk(clk), .sys_rst(sys_rst), .av_req(av_req),
  .av_waitrequest(av_waitrequest), .dma_ack_strobe(dma_ack_strobe), .periph_data_oe_n(periph_data_oe_n),
  .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_data(mem_wr_data));
